// ### sira_regs.sv
// Top of the subbank register access block: direct decode and four banks.
`timescale 1ns/1ps
`default_nettype none

module sira_regs (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [15:0] bus_wdata,
  output logic      [15:0] bus_rdata,
  output logic             bus_rd_valid,
  output logic      [15:0] dma_priority_enable_ctl,
  output logic      [15:0] dma_subaddr_pointer,
  output logic [2:0][15:0] serial_subaddr_pointer
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] rdata;     // Read answer, held until the next read.
    logic        rd_valid;  // One-cycle mark that rdata is fresh.
    logic [15:0] dmactl;    // Directly mapped DMA priority and enable control.
  } sira_top_state_t;

  sira_top_state_t state_reg;   // Registered state.
  sira_top_state_t state_next;  // Next state.

  logic [2:0]        sp_ptr_wr;    // Serial pointer write strobes.
  logic [2:0]        sp_data_sel;  // Serial data port selects.
  logic [2:0][15:0]  sp_rdata;     // Serial bank read data.
  logic [2:0]        sp_valid;     // Serial pointer names a real register.
  logic              dma_ptr_wr;   // DMA pointer write strobe.
  logic              dma_auto_sel; // Autoincrement data port selected.
  logic              dma_data_sel; // Either DMA data port selected.
  logic [15:0]       dma_rdata;    // DMA bank read data.
  logic              dma_valid;    // DMA pointer names a real register.

  // ---------------------------------------------------------------------------
  // Serial port banks
  // ---------------------------------------------------------------------------
  // One bank per port; each port owns its pointer and data locations.
  for (genvar gi = 0; gi < sira_pkg::SIRA_NUM_SP; gi++) begin : g_sp
    assign sp_ptr_wr[gi]   = bus_wr && (bus_addr == sira_pkg::SIRA_SP_PTR_ADDR[gi]);
    assign sp_data_sel[gi] = (bus_addr == sira_pkg::SIRA_SP_DATA_ADDR[gi]);

    sira_subbank #(
      .KIND (sira_pkg::SIRA_BANK_SERIAL)
    ) u_sp_bank (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .clk_en    (clk_en),
      .ptr_wr    (sp_ptr_wr[gi]),
      .data_wr   (bus_wr && sp_data_sel[gi]),
      .data_rd   (bus_rd && sp_data_sel[gi]),
      .autoinc   (1'b0),
      .wdata     (bus_wdata),
      .ptr       (serial_subaddr_pointer[gi]),
      .sub_valid (sp_valid[gi]),
      .rdata     (sp_rdata[gi])
    );
  end

  // ---------------------------------------------------------------------------
  // DMA bank
  // ---------------------------------------------------------------------------
  assign dma_ptr_wr   = bus_wr && (bus_addr == sira_pkg::SIRA_DMA_PTR_ADDR);
  assign dma_auto_sel = (bus_addr == sira_pkg::SIRA_DMA_AUTO_ADDR);
  // Both data ports reach the same bank; only the increment differs.
  assign dma_data_sel = dma_auto_sel || (bus_addr == sira_pkg::SIRA_DMA_PLAIN_ADDR);

  sira_subbank #(
    .KIND (sira_pkg::SIRA_BANK_DMA)
  ) u_dma_bank (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .ptr_wr    (dma_ptr_wr),
    .data_wr   (bus_wr && dma_data_sel),
    .data_rd   (bus_rd && dma_data_sel),
    .autoinc   (dma_auto_sel),
    .wdata     (bus_wdata),
    .ptr       (dma_subaddr_pointer),
    .sub_valid (dma_valid),
    .rdata     (dma_rdata)
  );

  // ---------------------------------------------------------------------------
  // Read mux and direct register
  // ---------------------------------------------------------------------------
  // Read data is registered so the answer never ripples from the address pins.
  always_comb begin
    state_next          = state_reg;
    state_next.rd_valid = bus_rd;
    if (bus_rd) begin
      case (bus_addr)
        sira_pkg::SIRA_SP_PTR_ADDR[0]:  state_next.rdata = serial_subaddr_pointer[0];
        sira_pkg::SIRA_SP_PTR_ADDR[1]:  state_next.rdata = serial_subaddr_pointer[1];
        sira_pkg::SIRA_SP_PTR_ADDR[2]:  state_next.rdata = serial_subaddr_pointer[2];
        sira_pkg::SIRA_SP_DATA_ADDR[0]: state_next.rdata = sp_rdata[0];
        sira_pkg::SIRA_SP_DATA_ADDR[1]: state_next.rdata = sp_rdata[1];
        sira_pkg::SIRA_SP_DATA_ADDR[2]: state_next.rdata = sp_rdata[2];
        sira_pkg::SIRA_DMA_CTL_ADDR:    state_next.rdata = state_reg.dmactl;
        sira_pkg::SIRA_DMA_PTR_ADDR:    state_next.rdata = dma_subaddr_pointer;
        sira_pkg::SIRA_DMA_AUTO_ADDR:   state_next.rdata = dma_rdata;
        sira_pkg::SIRA_DMA_PLAIN_ADDR:  state_next.rdata = dma_rdata;
        // Locations outside this block answer zero.
        default:                        state_next.rdata = sira_pkg::SIRA_RST_WORD;
      endcase
    end
    // The control register is reached without any pointer.
    if (bus_wr && bus_addr == sira_pkg::SIRA_DMA_CTL_ADDR) begin
      state_next.dmactl = bus_wdata;
    end
  end

  // Register the state; a low clock enable freezes everything.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign bus_rdata               = state_reg.rdata;
  assign bus_rd_valid            = state_reg.rd_valid;
  assign dma_priority_enable_ctl = state_reg.dmactl;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  auto_step_a: assert property (
    clk_en && (bus_rd || bus_wr) && bus_addr == sira_pkg::SIRA_DMA_AUTO_ADDR
    |=> dma_subaddr_pointer == 16'($past(dma_subaddr_pointer) + 16'h0001))
    else $error("Autoincrement port did not step the pointer by one.");

  plain_hold_a: assert property (
    clk_en && (bus_rd || bus_wr) && bus_addr == sira_pkg::SIRA_DMA_PLAIN_ADDR
    |=> $stable(dma_subaddr_pointer))
    else $error("Plain DMA port moved the pointer.");

  sp_ptr_load_a: assert property (
    clk_en && bus_wr && bus_addr == sira_pkg::SIRA_SP_PTR_ADDR[1]
    |=> serial_subaddr_pointer[1] == $past(bus_wdata))
    else $error("Serial port 1 pointer did not take the written value.");

  ctl_direct_a: assert property (
    clk_en && bus_wr && bus_addr == sira_pkg::SIRA_DMA_CTL_ADDR
    |=> dma_priority_enable_ctl == $past(bus_wdata) && $stable(dma_subaddr_pointer))
    else $error("Direct control write failed or touched the pointer.");

  // A frozen cycle holds the mark as it was, so only an enabled edge may clear it.
  rd_answer_a: assert property (
    clk_en && bus_rd
    |=> bus_rd_valid ##1 (!bus_rd_valid || $past(bus_rd) || !$past(clk_en)))
    else $error("Read answer mark missing or stretched.");

  // Every serial port must answer zero for a hole in its subaddress map.
  bad_sub_zero_a: assert property (
    clk_en && bus_rd
      && ((!sp_valid[0] && bus_addr == sira_pkg::SIRA_SP_DATA_ADDR[0])
        || (!sp_valid[1] && bus_addr == sira_pkg::SIRA_SP_DATA_ADDR[1])
        || (!sp_valid[2] && bus_addr == sira_pkg::SIRA_SP_DATA_ADDR[2]))
    |=> bus_rdata == 16'h0000)
    else $error("Unassigned serial subaddress did not read zero.");

  // Either DMA data port must answer zero once the pointer leaves the map.
  bad_dma_zero_a: assert property (
    clk_en && bus_rd && !dma_valid && dma_data_sel
    |=> bus_rdata == 16'h0000)
    else $error("Unassigned DMA subaddress did not read zero.");

  dma_ptr_load_a: assert property (
    clk_en && bus_wr && bus_addr == sira_pkg::SIRA_DMA_PTR_ADDR
    |=> dma_subaddr_pointer == $past(bus_wdata))
    else $error("DMA pointer did not take the written value.");

  // A low enable must hold the pointers, the control word and the read data, whatever request stands.
  frozen_state_a: assert property (
    !clk_en
    |=> $stable(dma_subaddr_pointer) && $stable(serial_subaddr_pointer)
      && $stable(dma_priority_enable_ctl) && $stable(bus_rdata))
    else $error("State moved while the clock enable was low.");

  wr_readback_a: assert property (
    (clk_en && bus_wr && sp_valid[0] && bus_addr == sira_pkg::SIRA_SP_DATA_ADDR[0])
    ##1 (clk_en && bus_rd && bus_addr == sira_pkg::SIRA_SP_DATA_ADDR[0])
    |=> bus_rdata == $past(bus_wdata, 2))
    else $error("Serial data port did not return the word just written.");

  ptr_then_read_a: assert property (
    (clk_en && bus_wr && bus_addr == sira_pkg::SIRA_DMA_PTR_ADDR
      && bus_wdata > sira_pkg::SIRA_DMA_LAST)
    ##1 (clk_en && bus_rd && bus_addr == sira_pkg::SIRA_DMA_PLAIN_ADDR)
    |=> bus_rdata == 16'h0000)
    else $error("Fresh pointer was not used by the next access.");

endmodule : sira_regs

`default_nettype wire

// ### sira_pkg.sv
// Constants, address map and subaddress decode for the subbank register access block.
package sira_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int SIRA_DATA_W = 16;  // Width of every data word and pointer.
  localparam int SIRA_IDX_W  = 6;   // Subaddress bits that index a bank.
  localparam int SIRA_DEPTH  = 64;  // Words held in one bank.
  localparam int SIRA_NUM_SP = 3;   // Number of buffered serial ports.

  // ---------------------------------------------------------------------------
  // Direct data-space addresses
  // ---------------------------------------------------------------------------
  // Serial pointer and data addresses, element n belongs to serial port n.
  localparam logic [2:0][15:0] SIRA_SP_PTR_ADDR  = {16'h0034, 16'h0048, 16'h0038};
  localparam logic [2:0][15:0] SIRA_SP_DATA_ADDR = {16'h0035, 16'h0049, 16'h0039};
  localparam logic [15:0] SIRA_DMA_CTL_ADDR   = 16'h0054;  // Priority and enable control.
  localparam logic [15:0] SIRA_DMA_PTR_ADDR   = 16'h0055;  // DMA subaddress pointer.
  localparam logic [15:0] SIRA_DMA_AUTO_ADDR  = 16'h0056;  // Data port with post-increment.
  localparam logic [15:0] SIRA_DMA_PLAIN_ADDR = 16'h0057;  // Data port without increment.

  // ---------------------------------------------------------------------------
  // Subaddress map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] SIRA_SP_CTL_FIRST  = 16'h0000;  // Serial control 1.
  localparam logic [15:0] SIRA_SP_PIN_CTL    = 16'h000E;  // Last of the base group.
  localparam logic [15:0] SIRA_SP_EXT_FIRST  = 16'h0010;  // First extra channel enable.
  localparam logic [15:0] SIRA_SP_EXT_LAST   = 16'h001B;  // Last extra channel enable.
  localparam logic [15:0] SIRA_DMA_CH_FIRST  = 16'h0000;  // Channel 0 source address.
  localparam logic [15:0] SIRA_DMA_CH_LAST   = 16'h001D;  // Channel 5 transfer mode.
  localparam logic [15:0] SIRA_DMA_SRC_PAGE  = 16'h001E;  // Shared source program page.
  localparam logic [15:0] SIRA_DMA_DST_PAGE  = 16'h001F;  // Shared destination page.
  localparam logic [15:0] SIRA_DMA_IDX_FIRST = 16'h0020;  // First index register.
  localparam logic [15:0] SIRA_DMA_RLD_FIRST = 16'h0024;  // First reload register.
  localparam logic [15:0] SIRA_DMA_LAST      = 16'h003D;  // Last reload register.

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] SIRA_RST_WORD = 16'h0000;  // Every register and pointer.
  localparam logic [15:0] SIRA_PTR_STEP = 16'h0001;  // Autoincrement step.

  // Which kind of bank a subaddress is decoded for.
  typedef enum logic {SIRA_BANK_SERIAL, SIRA_BANK_DMA} sira_bank_t;

  // True when the subaddress names an implemented register of that bank kind.
  function automatic logic sira_sub_valid(input sira_bank_t kind, input logic [15:0] sub);
    logic ok;
    ok = 1'b0;
    if (kind == SIRA_BANK_SERIAL) begin
      ok = (sub <= SIRA_SP_PIN_CTL) || (sub >= SIRA_SP_EXT_FIRST && sub <= SIRA_SP_EXT_LAST);
    end else begin
      ok = (sub <= SIRA_DMA_LAST);
    end
    return ok;
  endfunction : sira_sub_valid

endpackage : sira_pkg

// ### sira_subbank.sv
// One pointer-addressed register bank with its pointer and data port.
`timescale 1ns/1ps
`default_nettype none

module sira_subbank #(
  parameter sira_pkg::sira_bank_t KIND = sira_pkg::SIRA_BANK_SERIAL
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        ptr_wr,
  input  wire logic        data_wr,
  input  wire logic        data_rd,
  input  wire logic        autoinc,
  input  wire logic [15:0] wdata,
  output logic      [15:0] ptr,
  output logic             sub_valid,
  output logic      [15:0] rdata
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  // Pointer and storage travel together so one register process covers all.
  typedef struct packed {
    logic [15:0]                         ptr;  // Selected subaddress.
    logic [sira_pkg::SIRA_DEPTH-1:0][15:0] mem;  // Bank contents.
  } sira_bank_state_t;

  sira_bank_state_t state_reg;   // Registered state.
  sira_bank_state_t state_next;  // Next state.
  logic [sira_pkg::SIRA_IDX_W-1:0] idx;  // Word index taken from the pointer.

  // Only the low pointer bits index storage; the validity check covers the rest.
  assign idx       = state_reg.ptr[sira_pkg::SIRA_IDX_W-1:0];
  assign sub_valid = sira_pkg::sira_sub_valid(KIND, state_reg.ptr);
  assign ptr       = state_reg.ptr;
  // Unassigned subaddresses read as zero rather than aliasing onto storage.
  assign rdata     = sub_valid ? state_reg.mem[idx] : sira_pkg::SIRA_RST_WORD;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // The caller issues at most one of the three strobes per cycle.
  always_comb begin
    state_next = state_reg;
    if (ptr_wr) begin
      state_next.ptr = wdata;
    end else begin
      if (data_wr && sub_valid) begin
        state_next.mem[idx] = wdata;
      end
      // Step after the access, so the access itself used the old pointer.
      if ((data_wr || data_rd) && autoinc) begin
        state_next.ptr = 16'(state_reg.ptr + sira_pkg::SIRA_PTR_STEP);
      end
    end
  end

  // Register the state; a low clock enable freezes everything.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

endmodule : sira_subbank

`default_nettype wire

// ### test_subbank_indirect_register_access.sv
// Self-checking testbench for the subbank register access block.
`timescale 1ns/1ps
`default_nettype none

module test_subbank_indirect_register_access;
  // ---------------------------------------------------------------------------
  // Design signals, counters and the reference state
  // ---------------------------------------------------------------------------
  logic             core_clk;                 // 10 MHz processor clock.
  logic             resetn;                   // Asynchronous reset, active low.
  logic             clk_en;                   // Run enable, low freezes the block.
  logic      [15:0] bus_addr;                 // Direct data-space address.
  logic             bus_rd;                   // Read strobe.
  logic             bus_wr;                   // Write strobe.
  logic      [15:0] bus_wdata;                // Write data.
  logic      [15:0] bus_rdata;                // Registered read answer.
  logic             bus_rd_valid;             // One-cycle answer pulse.
  logic      [15:0] dma_priority_enable_ctl;  // Directly mapped DMA control.
  logic      [15:0] dma_subaddr_pointer;      // DMA bank pointer.
  logic [2:0][15:0] serial_subaddr_pointer;   // Serial bank pointers.
  int               failures;                 // Mismatches seen.
  int               checks;                   // Comparisons made.
  logic      [15:0] sp_mem [3][64];           // Expected serial bank words.
  logic      [15:0] dma_mem [64];             // Expected DMA bank words.
  logic      [15:0] sp_ptr [3];               // Expected serial pointers.
  logic      [15:0] dma_ptr;                  // Expected DMA pointer.
  logic      [15:0] ctl;                      // Expected DMA control word.
  // Random traffic mixes every mapped location with two holes.
  logic      [15:0] amap [12] = '{16'h0034, 16'h0035, 16'h0038, 16'h0039, 16'h0048, 16'h0049,
                                  16'h0054, 16'h0055, 16'h0056, 16'h0057, 16'h0036, 16'h0058};

  sira_regs u_dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rd_valid(bus_rd_valid), .dma_priority_enable_ctl(dma_priority_enable_ctl),
    .dma_subaddr_pointer(dma_subaddr_pointer), .serial_subaddr_pointer(serial_subaddr_pointer));

  // Free-running clock, 100 ns period.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------------------
  // Serial port number behind a pointer or data address.
  function automatic int sp_idx(input logic [15:0] a);
    return (a[7:4] == 4'h3 && a[3]) ? 0 : (a[7:4] == 4'h4) ? 1 : 2;
  endfunction : sp_idx

  // Serial subaddresses that hold a register; the gap at 0Fh does not.
  function automatic logic sp_ok(input logic [15:0] s);
    return s <= 16'h000E || (s >= 16'h0010 && s <= 16'h001B);
  endfunction : sp_ok

  // Word a read of this address should return under the current model.
  function automatic logic [15:0] expect_rd(input logic [15:0] a);
    int p;
    p = sp_idx(a);
    case (a)
      16'h0034, 16'h0038, 16'h0048: return sp_ptr[p];
      16'h0035, 16'h0039, 16'h0049: return sp_ok(sp_ptr[p]) ? sp_mem[p][sp_ptr[p][5:0]] : 16'h0000;
      16'h0054: return ctl;
      16'h0055: return dma_ptr;
      16'h0056, 16'h0057: return (dma_ptr <= 16'h003D) ? dma_mem[dma_ptr[5:0]] : 16'h0000;
      default: return 16'h0000;
    endcase
  endfunction : expect_rd

  // Applies a taken write to the model; unassigned places swallow it.
  task automatic model_wr(input logic [15:0] a, input logic [15:0] d);
    int p;
    p = sp_idx(a);
    case (a)
      16'h0034, 16'h0038, 16'h0048: sp_ptr[p] = d;
      16'h0035, 16'h0039, 16'h0049: if (sp_ok(sp_ptr[p])) sp_mem[p][sp_ptr[p][5:0]] = d;
      16'h0054: ctl = d;
      16'h0055: dma_ptr = d;
      16'h0056, 16'h0057: if (dma_ptr <= 16'h003D) dma_mem[dma_ptr[5:0]] = d;
      default: ;
    endcase
  endtask : model_wr

  // ---------------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string msg);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t %s seen %h want %h", $time, msg, seen, want);
    end
  endtask : check

  // Called at a rising edge: drives one request, which the next edge takes.
  // Outputs are judged 1 ns after that edge so its updates have landed.
  task automatic op(input logic en, input logic rd, input logic wr,
                    input logic [15:0] a, input logic [15:0] d);
    logic [15:0] want;
    want = expect_rd(a);
    clk_en    <= en;
    bus_rd    <= rd;
    bus_wr    <= wr;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge core_clk);
    if (en && wr) model_wr(a, d);
    if (en && (rd || wr) && a == 16'h0056) dma_ptr = dma_ptr + 16'h0001;
    fork
      begin
        #1;
        if (en) check({15'h0000, bus_rd_valid}, {15'h0000, rd}, "read valid");
        if (en && rd) check(bus_rdata, want, "read data");
        check(dma_subaddr_pointer, dma_ptr, "dma pointer");
        for (int i = 0; i < 3; i++) check(serial_subaddr_pointer[i], sp_ptr[i], "serial pointer");
        check(dma_priority_enable_ctl, ctl, "dma control");
      end
    join_none
  endtask : op

  // Lets pending checks finish, then resets the block and the model together.
  task automatic do_reset();
    @(posedge core_clk);
    resetn <= 1'b0;
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    dma_ptr = 16'h0000;
    ctl = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      dma_mem[i] = 16'h0000;
      for (int p = 0; p < 3; p++) sp_mem[p][i] = 16'h0000;
    end
    for (int p = 0; p < 3; p++) sp_ptr[p] = 16'h0000;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
  endtask : do_reset

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // The run needs about 740 cycles; a hang is cut well beyond that.
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    wrap_up();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [15:0] a;
    logic [15:0] d;
    int          k;
    {resetn, clk_en, bus_rd, bus_wr, bus_addr, bus_wdata} = '0;
    checks = 0;
    failures = 0;
    void'($urandom(56));
    do_reset();
    op(1, 1, 0, 16'h0056, 16'h0000);
    // Pointer write seen by the very next access, which then steps it.
    op(1, 0, 1, 16'h0055, 16'h0003);
    op(1, 1, 0, 16'h0056, 16'h0000);
    // Burst write then read across channel 5 and the shared pages.
    op(1, 0, 1, 16'h0055, 16'h001B);
    for (int i = 0; i < 8; i++) op(1, 0, 1, 16'h0056, 16'($urandom));
    op(1, 0, 1, 16'h0055, 16'h001B);
    for (int i = 0; i < 8; i++) op(1, 1, 0, 16'h0056, 16'h0000);
    // Plain port keeps the pointer on one register.
    op(1, 0, 1, 16'h0057, 16'h5A5A);
    op(1, 1, 0, 16'h0057, 16'h0000);
    // Top of the bank and beyond: writes past 3Dh vanish and read zero, pointer still steps.
    for (int r = 0; r < 2; r++) begin
      op(1, 0, 1, 16'h0055, 16'h003C);
      for (int i = 0; i < 4; i++) op(1, r == 1, r == 0, 16'h0056, 16'hFFFF);
    end
    // Pointer wraps from the top of its range.
    op(1, 0, 1, 16'h0055, 16'hFFFF);
    op(1, 1, 0, 16'h0057, 16'h0000);
    op(1, 1, 0, 16'h0056, 16'h0000);
    // Every serial subaddress of every port, written then read back.
    for (int p = 0; p < 3; p++) begin
      a = (p == 0) ? 16'h0038 : (p == 1) ? 16'h0048 : 16'h0034;
      for (int s = 0; s < 32; s++) begin
        op(1, 0, 1, a, 16'(s));
        op(1, 0, 1, a + 16'h0001, 16'($urandom));
        op(1, 1, 0, a + 16'h0001, 16'h0000);
      end
    end
    // Frozen clock enable: neither request may act.
    op(0, 0, 1, 16'h0055, 16'h0007);
    op(0, 1, 0, 16'h0056, 16'h0000);
    op(1, 1, 0, 16'h0055, 16'h0000);
    // Random traffic, written pointer values kept inside the bank range.
    for (int i = 0; i < 400; i++) begin
      a = amap[$urandom % 12];
      k = $urandom % 3;
      d = 16'($urandom);
      if (a inside {16'h0034, 16'h0038, 16'h0048, 16'h0055}) d = d & 16'h003F;
      op(($urandom % 8) != 0, k == 1, k == 2, a, d);
    end
    // A second reset in mid-run clears pointers and banks.
    op(1, 0, 0, 16'h0000, 16'h0000);
    do_reset();
    op(1, 1, 0, 16'h0039, 16'h0000);
    op(1, 0, 0, 16'h0000, 16'h0000);
    repeat (2) @(posedge core_clk);
    wrap_up();
  end
endmodule : test_subbank_indirect_register_access
`default_nettype wire
